// File: hdl/panel_port_pkg.sv
// Constants and types for the flat-panel differential output port
package panel_port_pkg;
  localparam logic [19:0] CTRL_ADDR = 20'he_1180;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WR_MASK = 32'hE1FF_07FC;
  localparam int BIT_ENABLE = 31;
  localparam int SEL_HI = 30;
  localparam int SEL_LO = 29;
  localparam int BIT_FORMAT = 24;
  localparam int BIT_HS_FLAG = 23;
  localparam int BIT_VS_FLAG = 22;
  localparam int BIT_VS_INV = 21;
  localparam int BIT_HS_INV = 20;
  localparam int BIT_DE_INV = 19;
  localparam int SEC_HI = 18;
  localparam int SEC_LO = 17;
  localparam int BIT_RSV_DUP = 16;
  localparam int BIT_PD_TRI = 10;
  localparam int PRI_HI = 9;
  localparam int PRI_LO = 8;
  localparam int MSB_HI = 7;
  localparam int MSB_LO = 6;
  localparam int SECONDARY_PAIR_CLOCK_HI = 5;
  localparam int SECONDARY_PAIR_CLOCK_LO = 4;
  localparam int SECD_HI = 3;
  localparam int SECD_LO = 2;
  localparam int BIT_DETECT = 1;
  localparam logic [1:0] SEL_RESERVED = 2'h3;
  localparam logic [1:0] SEC_NORMAL = 2'h0;
  localparam logic [1:0] SEC_FLAGS = 2'h3;
  localparam int PIX_W = 24;
  localparam int WORD_W = 27;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_DONE = 3;

  typedef enum logic [1:0] {
    LVL_OFF = 2'b00,
    LVL_ZERO = 2'b01,
    LVL_ACTIVE = 2'b11
  } lane_level_e;

  typedef enum logic [0:0] {
    PAIR_EMPTY = 1'b0,
    PAIR_HALF = 1'b1
  } pair_state_e;
endpackage

// File: hdl/panel_port.sv
// Panel port control: register, source capture, FIFO and lane formatting
`timescale 1ns/1ps
`default_nettype none

module pixel_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// Notes on behaviour
// - Enable bit 31 clear keeps the port in low power, every pair off.
// - A disable fuse stops the port enabling whatever software wrote.
// - Writes are ignored while the power sequencer protects the register.
// - Select 00/01/10 takes transcoder A/B/C; 11 is reserved.
// - Bit 24 picks 18.0/24.0 formats versus 24.1 format.
// - Dual channel with extra flags: bit 23 goes on second-channel hsync.
// - Dual channel with extra flags: bit 22 goes on second-channel vsync.
// - Bit 21 set sends vertical sync active low.
// - Bit 20 set sends horizontal sync active low.
// - Bit 19 set sends the pixel-valid indicator active low.
// - Field 18:17 picks second-channel control: normal, zeros, or flags.
// - Bit 16 fills reserved bit positions with zero or a duplicate.
// - Sequencer power-down: bit 10 picks zero volts or high impedance.
// - Field 9:8 caps first channel data, clock and fourth pair.
// - Sequencer power-down forces every port signal to power-down.
// - Field 7:6 caps both fourth pairs, selecting eight-bit colour.
// - Fourth pairs need their own field and their channel field.
// - Field 5:4 caps second clock, also capped by second data field.
// - Field 3:2 caps second channel; 01 or 11 means dual channel.
// - Read-only bit 1 reports the management data line caught at boot.
module panel_port (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic panel_power_on,
  input wire logic seq_write_protect,
  input wire logic port_fuse_disable,
  input wire logic mgmt_data_boot,
  input wire logic pix_clk,
  input wire logic [panel_port_pkg::PIX_W-1:0] src_a_rgb,
  input wire logic src_a_hs,
  input wire logic src_a_vs,
  input wire logic src_a_de,
  input wire logic [panel_port_pkg::PIX_W-1:0] src_b_rgb,
  input wire logic src_b_hs,
  input wire logic src_b_vs,
  input wire logic src_b_de,
  input wire logic [panel_port_pkg::PIX_W-1:0] src_c_rgb,
  input wire logic src_c_hs,
  input wire logic src_c_vs,
  input wire logic src_c_de,
  output logic pix_accept,
  input wire logic out_ready,
  output logic out_valid,
  output logic [17:0] a_rgb,
  output logic [5:0] a_msb,
  output logic [2:0] a_ctl,
  output logic a_rsv,
  output logic [17:0] b_rgb,
  output logic [5:0] b_msb,
  output logic [2:0] b_ctl,
  output logic b_rsv,
  output panel_port_pkg::lane_level_e a_level,
  output panel_port_pkg::lane_level_e a3_level,
  output panel_port_pkg::lane_level_e b_level,
  output panel_port_pkg::lane_level_e b3_level,
  output panel_port_pkg::lane_level_e secondary_pair_clock_level,
  output logic buf_oe
);
  import panel_port_pkg::*;

  function automatic lane_level_e to_level(input logic [1:0] f);
    to_level = (f == 2'b01) ? LVL_ZERO : (f == 2'b11) ? LVL_ACTIVE : LVL_OFF;
  endfunction

  function automatic lane_level_e lower(input lane_level_e x,
                                        input lane_level_e y);
    lower = (x == LVL_OFF || y == LVL_OFF) ? LVL_OFF :
            (x == LVL_ZERO || y == LVL_ZERO) ? LVL_ZERO : LVL_ACTIVE;
  endfunction

  // Packs {rsv, msb, rgb}; control bits are handled per channel
  function automatic logic [24:0] lanes(input logic [PIX_W-1:0] p,
                                        input logic fmt, input logic dup,
                                        input lane_level_e ld,
                                        input lane_level_e lm);
    logic [17:0] lo;
    logic [5:0] hi;
    lo = fmt ? {p[23:18], p[15:10], p[7:2]} : {p[21:16], p[13:8], p[5:0]};
    hi = fmt ? {p[17:16], p[9:8], p[1:0]} : {p[23:22], p[15:14], p[7:6]};
    if (ld != LVL_ACTIVE) lo = '0;
    if (lm != LVL_ACTIVE) hi = '0;
    lanes = {dup & hi[0], hi, lo};
  endfunction

  logic [31:0] ctrl;
  logic [2:0] ctl_sync1;
  logic [2:0] ctl_sync2;
  logic [WORD_W-1:0] src_sync1 [3];
  logic [WORD_W-1:0] src_sync2 [3];
  logic [1:0] pclk_sync;
  logic pclk_prev;
  logic mgmt_sync1;
  logic mgmt_sync2;
  logic detected;
  logic [1:0] boot_cnt;
  logic [WORD_W-1:0] first_word;
  pair_state_e pair_state;
  pair_state_e next_pair_state;

  wire panel_on_s = ctl_sync2[0];
  wire protect_s = ctl_sync2[1];
  wire fuse_s = ctl_sync2[2];
  wire addr_hit = reg_addr == CTRL_ADDR;
  wire wr_ok = reg_wr && addr_hit && !protect_s;
  wire [31:0] rd_word = addr_hit ?
      ((ctrl & CTRL_WR_MASK) | (32'(detected) << BIT_DETECT)) : '0;
  wire [1:0] sel = ctrl[SEL_HI:SEL_LO];
  wire [1:0] sec_ctl = ctrl[SEC_HI:SEC_LO];
  wire fmt = ctrl[BIT_FORMAT];
  wire dup = ctrl[BIT_RSV_DUP];
  wire port_en = ctrl[BIT_ENABLE] && !fuse_s;
  wire port_on = port_en && panel_on_s;

  // Joint lane caps, lower level wins
  wire lane_level_e lvl_a = port_on ? to_level(ctrl[PRI_HI:PRI_LO]) :
                                      LVL_OFF;
  wire lane_level_e lvl_b = port_on ? to_level(ctrl[SECD_HI:SECD_LO]) :
                                      LVL_OFF;
  wire lane_level_e lvl_m = to_level(ctrl[MSB_HI:MSB_LO]);
  wire lane_level_e lvl_a3 = lower(lvl_m, lvl_a);
  wire lane_level_e lvl_b3 = lower(lvl_m, lvl_b);
  wire lane_level_e lvl_cb =
      lower(to_level(ctrl[SECONDARY_PAIR_CLOCK_HI:SECONDARY_PAIR_CLOCK_LO]), lvl_b);
  wire dual = lvl_b != LVL_OFF;

  // Sample on the falling pixel edge, half a period after data launch
  wire pclk_fall = pclk_prev && !pclk_sync[1];
  wire push = pclk_fall && port_en && sel != SEL_RESERVED;
  wire [WORD_W-1:0] src_word = src_sync2[sel];
  wire fifo_valid;
  wire [WORD_W-1:0] fifo_data;
  wire emit_single = !dual && out_ready;
  wire emit_pair = dual && pair_state == PAIR_HALF && out_ready;
  wire take_first = dual && pair_state == PAIR_EMPTY;
  wire pop = fifo_valid && (!port_on || emit_single || emit_pair ||
                            take_first);
  wire emit = fifo_valid && port_on && (emit_single || emit_pair);
  wire [WORD_W-1:0] word_a = emit_pair ? first_word : fifo_data;

  wire [2:0] pol = {ctrl[BIT_DE_INV], ctrl[BIT_VS_INV],
                    ctrl[BIT_HS_INV]};
  wire [2:0] ctl_a = (lvl_a == LVL_OFF) ? 3'h0 :
                     word_a[WORD_W-1:PIX_W] ^ pol;
  wire [2:0] ctl_b_norm = fifo_data[WORD_W-1:PIX_W] ^ pol;
  wire [2:0] ctl_b = (lvl_b == LVL_OFF) ? 3'h0 :
                     (sec_ctl == SEC_NORMAL) ? ctl_b_norm :
                     (sec_ctl == SEC_FLAGS) ?
                     {1'b0, ctrl[BIT_VS_FLAG], ctrl[BIT_HS_FLAG]} :
                     3'h0;
  wire [24:0] lanes_a = lanes(word_a[PIX_W-1:0], fmt, dup, lvl_a,
                              lvl_a3);
  wire [24:0] lanes_b = dual ? lanes(fifo_data[PIX_W-1:0], fmt, dup,
                                     lvl_b, lvl_b3) : '0;

  always_comb begin
    next_pair_state = pair_state;
    case (pair_state)
      PAIR_EMPTY: begin
        if (pop && take_first && port_on) next_pair_state = PAIR_HALF;
      end
      PAIR_HALF: begin
        if (!port_on || !dual || (pop && emit_pair)) begin
          next_pair_state = PAIR_EMPTY;
        end
      end
      default: next_pair_state = PAIR_EMPTY;
    endcase
  end

  pixel_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(pix_accept),
    .in_data(src_word),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_sync1 <= '0;
      ctl_sync2 <= '0;
      pclk_sync <= '0;
      pclk_prev <= 1'b0;
      mgmt_sync1 <= 1'b0;
      mgmt_sync2 <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        src_sync1[i] <= '0;
        src_sync2[i] <= '0;
      end
    end else begin
      ctl_sync1 <= {port_fuse_disable, seq_write_protect, panel_power_on};
      ctl_sync2 <= ctl_sync1;
      pclk_sync <= {pclk_sync[0], pix_clk};
      pclk_prev <= pclk_sync[1];
      mgmt_sync1 <= mgmt_data_boot;
      mgmt_sync2 <= mgmt_sync1;
      src_sync1[0] <= {src_a_de, src_a_vs, src_a_hs, src_a_rgb};
      src_sync1[1] <= {src_b_de, src_b_vs, src_b_hs, src_b_rgb};
      src_sync1[2] <= {src_c_de, src_c_vs, src_c_hs, src_c_rgb};
      for (int i = 0; i < 3; i++) src_sync2[i] <= src_sync1[i];
    end
  end

  // Detect level is caught once, after the synchroniser has filled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt <= '0;
      detected <= 1'b0;
    end else if (boot_cnt != 2'(SYNC_DONE)) begin
      boot_cnt <= boot_cnt + 1'b1;
      if (boot_cnt == 2'(SYNC_DONE - 1)) detected <= mgmt_sync2;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      reg_rdata <= '0;
    end else begin
      if (wr_ok) ctrl <= reg_wdata & CTRL_WR_MASK;
      if (reg_rd) reg_rdata <= rd_word;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pair_state <= PAIR_EMPTY;
      first_word <= '0;
      out_valid <= 1'b0;
      {a_rsv, a_msb, a_rgb} <= '0;
      {b_rsv, b_msb, b_rgb} <= '0;
      a_ctl <= '0;
      b_ctl <= '0;
    end else begin
      pair_state <= next_pair_state;
      out_valid <= emit;
      if (pop && take_first) first_word <= fifo_data;
      if (emit) begin
        {a_rsv, a_msb, a_rgb} <= lanes_a;
        {b_rsv, b_msb, b_rgb} <= lanes_b;
        a_ctl <= ctl_a;
        b_ctl <= ctl_b;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_level <= LVL_OFF;
      a3_level <= LVL_OFF;
      b_level <= LVL_OFF;
      b3_level <= LVL_OFF;
      secondary_pair_clock_level <= LVL_OFF;
      buf_oe <= 1'b1;
    end else begin
      a_level <= lvl_a;
      a3_level <= lvl_a3;
      b_level <= lvl_b;
      b3_level <= lvl_b3;
      secondary_pair_clock_level <= lvl_cb;
      buf_oe <= port_on || !ctrl[BIT_PD_TRI];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_pair_start;
    dual && pair_state == PAIR_HALF && fifo_valid && port_on && out_ready;
  endsequence

  sequence s_flag_emit;
    s_pair_start ##0 sec_ctl == SEC_FLAGS;
  endsequence

  a_write_protect: assert property (
    reg_wr && addr_hit && protect_s |=> $stable(ctrl))
    else $error("protected write changed the control register");
  a_fuse_blocks: assert property (
    fuse_s ##1 fuse_s |-> a_level == LVL_OFF && b_level == LVL_OFF)
    else $error("fuse did not hold the port off");
  a_disable_off: assert property (
    !ctrl[BIT_ENABLE] |=> a_level == LVL_OFF && secondary_pair_clock_level == LVL_OFF)
    else $error("disabled port has a lane powered");
  a_seq_powerdown: assert property (
    !panel_on_s |=> a3_level == LVL_OFF && b3_level == LVL_OFF)
    else $error("lane powered while sequencer is down");
  a_buffer_state: assert property (
    ctrl[BIT_ENABLE] && !panel_on_s |=> buf_oe == !$past(ctrl[BIT_PD_TRI]))
    else $error("power-down buffer state wrong");
  a_msb_capped: assert property (
    a3_level == LVL_ACTIVE |-> $past(ctrl[PRI_HI:PRI_LO]) == 2'b11 &&
                               $past(ctrl[MSB_HI:MSB_LO]) == 2'b11)
    else $error("fourth pair active without both fields");
  a_extra_flags: assert property (
    s_flag_emit |=> out_valid && b_ctl ==
      {1'b0, $past(ctrl[BIT_VS_FLAG]), $past(ctrl[BIT_HS_FLAG])})
    else $error("second channel flags not sent");
  a_select_reserved: assert property (
    sel == SEL_RESERVED |-> !push)
    else $error("reserved transcoder select took data");
  a_detect_read: assert property (
    reg_rd && addr_hit |=> reg_rdata[BIT_DETECT] == $past(detected))
    else $error("detect bit read wrong");
  a_zero_data: assert property (
    out_valid && a_level == LVL_ZERO |-> a_rgb == '0)
    else $error("forced-zero data nonzero");
endmodule

`default_nettype wire

// File: bench/panel_sink.sv
// Behavioural panel receiver taking lane words at full or reduced rate
`timescale 1ns/1ps
`default_nettype none
module panel_sink (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic out_valid,
  output logic out_ready,
  output logic [15:0] words
);
  logic phase;
  // Mode 0 always ready, 1 every other cycle, 2 stalled
  assign out_ready = rst_n && (mode == 2'h0 || (mode == 2'h1 && phase));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      words <= 16'h0000;
    end else begin
      phase <= ~phase;
      if (out_valid) begin
        words <= words + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/panel_port_test.sv
// Self-checking bench for the panel port control block
`timescale 1ns/1ps
`default_nettype none
module panel_port_test;
  import panel_port_pkg::*;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pix_clk = 0;
  logic [19:0] reg_addr = 20'h0_0000;
  logic [31:0] reg_wdata = 32'h0000_0000, rv, cur = 32'h0000_0000;
  logic panel_power_on = 0, seq_write_protect = 0, port_fuse_disable = 0;
  logic mgmt_data_boot = 1;
  logic [2:0] tim = 3'h5;
  logic [23:0] src_a_rgb = 24'hC6_C6C6, src_b_rgb = 24'h39_3939;
  logic [23:0] src_c_rgb = 24'h5A_5A5A;
  logic src_a_hs, src_a_vs, src_a_de, src_b_hs, src_b_vs, src_b_de;
  logic src_c_hs, src_c_vs, src_c_de, pix_accept, out_ready, out_valid;
  logic [17:0] a_rgb, b_rgb;
  logic [5:0] a_msb, b_msb;
  logic [2:0] a_ctl, b_ctl;
  logic a_rsv, b_rsv, buf_oe;
  lane_level_e a_level, a3_level, b_level, b3_level, secondary_pair_clock_level;
  logic [1:0] sink_mode = 2'h0;
  logic [15:0] words, held;
  int error_cnt = 0, num_checks = 0;
  assign {src_a_de, src_a_vs, src_a_hs} = tim;
  assign {src_b_de, src_b_vs, src_b_hs} = tim;
  assign {src_c_de, src_c_vs, src_c_hs} = tim;

  panel_port dut_u (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata(rv), .panel_power_on, .seq_write_protect,
    .port_fuse_disable, .mgmt_data_boot, .pix_clk, .src_a_rgb, .src_a_hs,
    .src_a_vs, .src_a_de, .src_b_rgb, .src_b_hs, .src_b_vs, .src_b_de,
    .src_c_rgb, .src_c_hs, .src_c_vs, .src_c_de, .pix_accept, .out_ready,
    .out_valid, .a_rgb, .a_msb, .a_ctl, .a_rsv, .b_rgb, .b_msb, .b_ctl,
    .b_rsv, .a_level, .a3_level, .b_level, .b3_level, .secondary_pair_clock_level, .buf_oe);
  panel_sink sink_u (.clk_sys(clk_sys), .rst_n(rst_n), .mode(sink_mode),
    .out_valid(out_valid), .out_ready(out_ready), .words(words));

  initial forever #12.5 clk_sys = ~clk_sys;
  // Pixel clock is free running at one eighth of the system clock rate
  initial forever #100 pix_clk = ~pix_clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 0;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 0;
    @(negedge clk_sys);
    chk(rv, e);
  endtask

  task automatic wait_valid(input int n);
    int k;
    k = 0;
    for (int i = 0; i < 4000 && k < n; i++) begin
      @(negedge clk_sys);
      if (out_valid === 1'b1) k++;
    end
    chk(32'(k), 32'(n));
  endtask

  // Lower of two activity levels; reserved codes count as off
  function automatic logic [1:0] cap(input logic [1:0] x, input logic [1:0] y);
    logic [1:0] rx, ry;
    rx = (x == 2'h3) ? 2'd2 : (x == 2'h1) ? 2'd1 : 2'd0;
    ry = (y == 2'h3) ? 2'd2 : (y == 2'h1) ? 2'd1 : 2'd0;
    rx = (ry < rx) ? ry : rx;
    return (rx == 2'd2) ? 2'h3 : (rx == 2'd1) ? 2'h1 : 2'h0;
  endfunction

  function automatic logic [31:0] lv();
    return 32'({a_level, a3_level, b_level, b3_level, secondary_pair_clock_level});
  endfunction

  // Panel off and port disabled before any change; enable precedes power-on
  task automatic cfg(input logic [31:0] c);
    panel_power_on = 0;
    wr(CTRL_ADDR, {1'b0, cur[30:0]});
    wr(CTRL_ADDR, {1'b0, c[30:0]});
    wr(CTRL_ADDR, c);
    panel_power_on = 1;
    cur = c;
  endtask

  task automatic t_regs();
    rd(CTRL_ADDR, 32'h0000_0002);
    rd(20'h0_0100, 32'h0000_0000);
    chk(lv(), 32'h0);
    chk(32'(buf_oe), 32'h1);
    wr(CTRL_ADDR, 32'hFFFF_FFFF);
    wr(20'h0_0100, 32'h0000_0000);
    rd(CTRL_ADDR, 32'hE1FF_07FE);
    chk(lv(), 32'h0);
    chk(32'(buf_oe), 32'h0);
    seq_write_protect = 1;
    repeat (4) @(negedge clk_sys);
    wr(CTRL_ADDR, 32'h0000_0000);
    rd(CTRL_ADDR, 32'hE1FF_07FE);
    seq_write_protect = 0;
    repeat (4) @(negedge clk_sys);
    wr(CTRL_ADDR, 32'h6000_0000);
    rd(CTRL_ADDR, 32'h6000_0002);
    wr(CTRL_ADDR, 32'h0000_0000);
    $display("register test done");
  endtask

  task automatic t_levels();
    logic [7:0] tab [7] = '{8'hFF, 8'h5F, 8'hF5, 8'hAA, 8'hD3, 8'h3C, 8'h7D};
    logic [1:0] a, b;
    wr(CTRL_ADDR, 32'h8000_0000);
    panel_power_on = 1;
    foreach (tab[i]) begin
      wr(CTRL_ADDR, {3'b100, 19'h0_0000, tab[i], 2'b00});
      a = cap(tab[i][7:6], 2'h3);
      b = cap(tab[i][1:0], 2'h3);
      chk(lv(), 32'({a, cap(tab[i][5:4], a), b, cap(tab[i][5:4], b),
          cap(tab[i][3:2], b)}));
    end
    port_fuse_disable = 1;
    repeat (5) @(negedge clk_sys);
    chk(lv(), 32'h0);
    port_fuse_disable = 0;
    panel_power_on = 0;
    repeat (5) @(negedge clk_sys);
    chk(lv(), 32'h0);
    panel_power_on = 1;
    wr(CTRL_ADDR, 32'h0000_03FC);
    chk(lv(), 32'h0);
    $display("level test done");
  endtask

  task automatic t_fifo();
    sink_mode = 2'h2;
    cfg(32'h8000_0300);
    repeat (150) @(negedge clk_sys);
    chk(32'(pix_accept), 32'h0);
    sink_mode = 2'h0;
    wait_valid(9);
    repeat (20) @(negedge clk_sys);
    chk(32'(pix_accept), 32'h1);
    $display("buffer test done");
  endtask

  task automatic pix(input logic [31:0] c, input logic [7:0] by,
                     input logic [2:0] t);
    logic f;
    f = c[BIT_FORMAT];
    tim = t;
    cfg(c);
    wait_valid(4);
    chk(32'({a_rgb, a_msb}), f ? 32'({{3{by[7:2]}}, {3{by[1:0]}}}) :
        32'({{3{by[5:0]}}, {3{by[7:6]}}}));
    chk(32'(a_ctl), 32'(t ^ {c[19], c[21], c[20]}));
    chk(32'(a_rsv), 32'(c[16] & (f ? by[0] : by[6])));
  endtask

  task automatic t_data();
    logic [31:0] tab [4] = '{32'h8086_03FC, 32'h8046_03FC, 32'h8000_03FC,
                             32'h8004_03FC};
    logic [2:0] exp_b [4] = '{3'h1, 3'h2, 3'h5, 3'h0};
    sink_mode = 2'h1;
    pix(32'h8001_03C0, 8'hC6, 3'h5);
    pix(32'hA139_03C0, 8'h39, 3'h5);
    pix(32'hC121_03C0, 8'h5A, 3'h3);
    pix(32'hC000_03C0, 8'h5A, 3'h6);
    cfg(32'hE000_03C0);
    repeat (40) @(negedge clk_sys);
    held = words;
    repeat (200) @(negedge clk_sys);
    chk(32'(words), 32'(held));
    tim = 3'h5;
    foreach (tab[i]) begin
      cfg(tab[i]);
      wait_valid(4);
      chk(32'(b_ctl), 32'(exp_b[i]));
      chk(32'({b_rgb, b_msb}), 32'({{3{6'h06}}, {3{2'h3}}}));
      chk(32'(b_rsv), 32'(tab[i][BIT_RSV_DUP]));
    end
    // First channel forced to zero: colour cleared, timing kept
    cfg(32'h8000_01C0);
    wait_valid(2);
    chk(32'({a_rgb, a_msb, a_rsv}), 32'h0);
    chk(32'(a_ctl), 32'h5);
    $display("data test done");
  endtask

  initial begin
    #2_000_000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1;
    repeat (6) @(negedge clk_sys);
    t_regs();
    t_levels();
    t_fifo();
    t_data();
    report_and_stop();
  end
endmodule
`default_nettype wire
